// ### rtl/dmc_top.sv
// Mute control logic for a four stereo channel DAC
//
// What this block does
// - Direct mute follows the completed register write
// - Four-bit mask, bit n mutes channel n+1
// - Global softmute bit mutes all channels
// - High mute pin mutes decoded channels
// - Low pin means no automute, manual mutes work
// - Decode bypass mutes all on high pin
// - Selector chooses channels muted by the pin
// - 1024 zero samples raise the channel zero flag
// - Pin driven high from selected zero flags
// - Own pin level feeds the same decoder
// - Clamp enable clamps zero or manually muted channels
// - Clamp enable at bit 4, default off
// - Clamp only under software control mode
// - Mask fields at documented bits, default zero
// - Softmute gain drops by 1/64 of itself each sample, releases instantly
`include "dmc_regs.svh"
`default_nettype none
module dmc_top
  import dmc_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter int ZERO_RUN = `DMC_ZERO_RUN
)(
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  wr_en_i,
  input  wire logic [`DMC_ADDR_W-1:0] wr_addr_i,
  input  wire logic [`DMC_DATA_W-1:0] wr_data_i,
  input  wire logic [`DMC_ADDR_W-1:0] rd_addr_i,
  output logic      [`DMC_DATA_W-1:0] rd_data_o,
  input  wire logic                  mode_sel_i,
  input  wire logic                  sample_stb_i,
  input  wire logic [8*SAMPLE_W-1:0] sample_data_i,
  input  wire logic                  mute_pin_i,
  output logic                       mute_pin_o,
  output logic                       mute_pin_oe_o,
  output logic      [3:0]            zero_run_flag_o,
  output logic      [3:0]            softmute_o,
  output logic      [3:0]            clamp_o,
  output logic      [63:0]           gain_o
);

  localparam int CNT_W = $clog2(ZERO_RUN + 1);

  // Channels muted by a high pin for a selector value
  function automatic dmc_chmask_t pin_decode(input dmc_sel_t sel, input logic bypass);
    dmc_chmask_t m;
    m = 4'hf;
    if (!bypass)
    begin
      unique case (sel)
        3'h0: m = 4'hf;
        3'h1: m = 4'h1;
        3'h2: m = 4'h2;
        3'h3: m = 4'h4;
        3'h4: m = 4'h8;
        3'h5: m = 4'h3;
        3'h6: m = 4'h7;
        3'h7: m = 4'hc;
      endcase
    end
    return m;
  endfunction

  // Zero flags that must all be high to drive the pin
  function automatic dmc_chmask_t flag_need(input dmc_sel_t sel);
    dmc_chmask_t m;
    m = 4'hf;
    unique case (sel)
      3'h0: m = 4'hf;
      3'h1: m = 4'h1;
      3'h2: m = 4'h2;
      3'h3: m = 4'h4;
      3'h4: m = 4'h8;
      3'h5: m = 4'h3;
      3'h6: m = 4'h7;
      3'h7: m = 4'hc;
    endcase
    return m;
  endfunction

  dmc_reg_t               reg_glob_q, reg_glob_d;
  dmc_reg_t               reg_chsel_q, reg_chsel_d;
  dmc_reg_t               reg_ch4_q, reg_ch4_d;
  logic [`DMC_DATA_W-1:0] rd_data_q, rd_data_d;

  always_comb
  begin
    reg_glob_d  = reg_glob_q;
    reg_chsel_d = reg_chsel_q;
    reg_ch4_d   = reg_ch4_q;
    if (wr_en_i)
    begin
      unique case (wr_addr_i)
        `DMC_OFS_GLOBAL: reg_glob_d  = wr_data_i;
        `DMC_OFS_CHSEL:  reg_chsel_d = wr_data_i;
        `DMC_OFS_CH4:    reg_ch4_d   = wr_data_i;
        default:         reg_glob_d  = reg_glob_q;
      endcase
    end
    unique case (rd_addr_i)
      `DMC_OFS_GLOBAL: rd_data_d = reg_glob_q;
      `DMC_OFS_CHSEL:  rd_data_d = reg_chsel_q;
      `DMC_OFS_CH4:    rd_data_d = reg_ch4_q;
      default:         rd_data_d = `DMC_RST_REG;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reg_glob_q  <= `DMC_RST_REG;
      reg_chsel_q <= `DMC_RST_REG;
      reg_ch4_q   <= `DMC_RST_REG;
      rd_data_q   <= `DMC_RST_REG;
    end
    else
    begin
      reg_glob_q  <= reg_glob_d;
      reg_chsel_q <= reg_chsel_d;
      reg_ch4_q   <= reg_ch4_d;
      rd_data_q   <= rd_data_d;
    end
  end

  dmc_chmask_t direct_mask;
  dmc_sel_t    sel;
  logic        gmute;
  logic        bypass;
  logic        clamp_en;

  always_comb
  begin
    direct_mask = {reg_ch4_q[`DMC_BIT_CH4_MUTE],
                   reg_chsel_q[`DMC_BIT_MASK_HI:`DMC_BIT_MASK_LO]};
    sel         = {reg_ch4_q[`DMC_BIT_SEL_MSB], reg_chsel_q[`DMC_BIT_SEL_HI:`DMC_BIT_SEL_LO]};
    gmute       = reg_glob_q[`DMC_BIT_GMUTE];
    bypass      = reg_glob_q[`DMC_BIT_BYPASS];
    clamp_en    = reg_glob_q[`DMC_BIT_CLAMP_EN];
  end

  // Zero run counters, one per stereo channel
  logic [CNT_W-1:0] cnt_q [4];
  logic [CNT_W-1:0] cnt_d [4];
  dmc_chmask_t      zrun_q, zrun_d;

  always_comb
  begin
    zrun_d = zrun_q;
    for (int c = 0; c < 4; c++)
    begin
      cnt_d[c] = cnt_q[c];
      if (sample_stb_i)
      begin
        if (sample_data_i[c*2*SAMPLE_W +: 2*SAMPLE_W] != '0)
        begin
          cnt_d[c]   = '0;
          zrun_d[c] = 1'b0;
        end
        else if (cnt_q[c] < CNT_W'(ZERO_RUN))
        begin
          cnt_d[c] = cnt_q[c] + CNT_W'(1);
          if (cnt_q[c] == CNT_W'(ZERO_RUN - 1))
            zrun_d[c] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int c = 0; c < 4; c++)
        cnt_q[c] <= '0;
      zrun_q <= '0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      zrun_q  <= zrun_d;
    end
  end

  // Mute combination, pin and clamp
  // The pin is a weak drive; an external driver wins and pin_i is the resolved level
  dmc_chmask_t mute_q, mute_d;
  dmc_chmask_t clamp_q, clamp_d;
  logic        pin_q, pin_d;
  logic        oe_q;

  always_comb
  begin
    pin_d = (zrun_q & flag_need(sel)) == flag_need(sel);
    // Automute only reaches channels through the pin level, so low pin blocks it
    // Pin ignored until the weak drive is on, else a floating pin mutes after reset
    mute_d = direct_mask
           | {4{gmute}}
           | ((mute_pin_i && oe_q) ? pin_decode(sel, bypass) : 4'h0);
    clamp_d = 4'h0;
    if (clamp_en && !mode_sel_i)
      clamp_d = zrun_q | direct_mask | {4{gmute}};
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mute_q  <= '0;
      clamp_q <= '0;
      pin_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else
    begin
      mute_q  <= mute_d;
      clamp_q <= clamp_d;
      pin_q   <= pin_d;
      oe_q    <= 1'b1;
    end
  end

  // Softmute gain, first order decay per sample
  logic [15:0] gain_q [4];
  logic [15:0] gain_d [4];

  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      gain_d[c] = gain_q[c];
      if (!mute_q[c])
        gain_d[c] = `DMC_GAIN_FULL;
      else if (sample_stb_i)
        gain_d[c] = gain_q[c] - (gain_q[c] >> `DMC_DECAY_SHIFT);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int c = 0; c < 4; c++)
        gain_q[c] <= `DMC_GAIN_FULL;
    end
    else
      gain_q <= gain_d;
  end

  always_comb
  begin
    rd_data_o       = rd_data_q;
    mute_pin_o      = pin_q;
    mute_pin_oe_o   = oe_q;
    zero_run_flag_o = zrun_q;
    softmute_o      = mute_q;
    clamp_o         = clamp_q;
    gain_o          = {gain_q[3], gain_q[2], gain_q[1], gain_q[0]};
  end

endmodule // dmc_top
`default_nettype wire

// ### shared/dmc_regs.svh
// Register offsets, field positions, reset values and counts of the mute block
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_ADDR_W          7
`define DMC_DATA_W          9
`define DMC_OFS_GLOBAL      7'h02
`define DMC_OFS_CHSEL       7'h09
`define DMC_OFS_CH4         7'h0f
`define DMC_BIT_GMUTE       0
`define DMC_BIT_BYPASS      3
`define DMC_BIT_CLAMP_EN    4
`define DMC_BIT_SEL_LO      1
`define DMC_BIT_SEL_HI      2
`define DMC_BIT_MASK_LO     3
`define DMC_BIT_MASK_HI     5
`define DMC_BIT_SEL_MSB     0
`define DMC_BIT_CH4_MUTE    2
`define DMC_RST_REG         9'h000
`define DMC_ZERO_RUN        1024
`define DMC_DECAY_SHIFT     6
`define DMC_GAIN_FULL       16'hffff
`endif

// ### shared/dmc_pkg.sv
// Types shared by the mute control block
`default_nettype none
package dmc_pkg;
  typedef logic [3:0] dmc_chmask_t;
  typedef logic [2:0] dmc_sel_t;
  typedef logic [8:0] dmc_reg_t;
endpackage
`default_nettype wire

// ### sim/dmc_props.sv
// Port-level checks of the mute control block
`default_nettype none
module dmc_props #(
  parameter int SAMPLE_W = 24
)(
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire logic                  wr_en_i,
  input wire logic [6:0]            wr_addr_i,
  input wire logic [8:0]            wr_data_i,
  input wire logic                  mode_sel_i,
  input wire logic                  sample_stb_i,
  input wire logic [8*SAMPLE_W-1:0] sample_data_i,
  input wire logic [3:0]            zero_run_flag_o,
  input wire logic [3:0]            softmute_o,
  input wire logic [3:0]            clamp_o,
  input wire logic [63:0]           gain_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr(logic [6:0] a);
    wr_en_i && wr_addr_i == a;
  endsequence
  // Mute held across the strobe, so the internal mute was on there
  sequence s_mute_strobe;
    softmute_o[0] && sample_stb_i ##1 softmute_o[0];
  endsequence
  AST_GMUTE: assert property (s_wr(7'h02) ##0 wr_data_i[0] |-> ##2 softmute_o == 4'hf)
    else $error("global mute missing");
  AST_MASK: assert property (s_wr(7'h09) |-> ##2 (softmute_o[2:0] & $past(wr_data_i[5:3], 2)) == $past(wr_data_i[5:3], 2))
    else $error("mask mute missing");
  AST_CH4: assert property (s_wr(7'h0f) ##0 wr_data_i[2] |-> ##2 softmute_o[3])
    else $error("ch4 mute missing");
  AST_CLAMP: assert property ($past(mode_sel_i) |-> clamp_o == 4'h0)
    else $error("clamp in pin mode");
  AST_ZCLR: assert property (sample_stb_i && |sample_data_i[2*SAMPLE_W-1:0] |=> !zero_run_flag_o[0])
    else $error("flag not cleared");
  AST_ZSET: assert property ($rose(zero_run_flag_o[3]) |-> $past(sample_stb_i))
    else $error("flag without strobe");
  AST_DECAY: assert property (s_mute_strobe |-> gain_o[15:0] == $past(gain_o[15:0]) - ($past(gain_o[15:0]) >> 6))
    else $error("bad decay step");
  AST_REL: assert property ($fell(softmute_o[0]) |-> ##[0:1] gain_o[15:0] == 16'hffff)
    else $error("slow release");
endmodule // dmc_props
bind dmc_top dmc_props #(.SAMPLE_W(SAMPLE_W)) u_props (
  .clk_i           (clk_i),
  .rstn_i          (rstn_i),
  .wr_en_i         (wr_en_i),
  .wr_addr_i       (wr_addr_i),
  .wr_data_i       (wr_data_i),
  .mode_sel_i      (mode_sel_i),
  .sample_stb_i    (sample_stb_i),
  .sample_data_i   (sample_data_i),
  .zero_run_flag_o (zero_run_flag_o),
  .softmute_o      (softmute_o),
  .clamp_o         (clamp_o),
  .gain_o          (gain_o)
);
`default_nettype wire

// ### sim/dmc_pin_model.sv
// External mute circuitry on the mute pin
`default_nettype none
module dmc_pin_model (
  input  wire logic ext_drive_i,
  input  wire logic ext_level_i,
  input  wire logic mute_pin_o,
  input  wire logic mute_pin_oe_o,
  output logic      mute_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strong outside drive beats the weak device drive
  assign mute_pin_i = ext_drive_i ? ext_level_i :
                      mute_pin_oe_o ? mute_pin_o : !mute_pin_o;
endmodule // dmc_pin_model
`default_nettype wire

// ### sim/dac_mute_control_logic_test.sv
// Self-checking bench of the mute control block
`default_nettype none
module dac_mute_control_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_i = 0, rstn_i = 0, wr_en_i = 0, mode_sel_i = 0, sample_stb_i = 0;
  logic         ext_drive_i = 0, ext_level_i = 0, mute_pin_i, mute_pin_o, mute_pin_oe_o;
  logic [6:0]   wr_addr_i = '0, rd_addr_i = '0;
  logic [8:0]   wr_data_i = '0, rd_data_o;
  logic [191:0] sample_data_i = '0;
  logic [3:0]   zero_run_flag_o, softmute_o, clamp_o;
  logic [63:0]  gain_o;
  int           mismatches = 0, checked = 0;
  logic [3:0]   dec [8] = '{4'hf, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h7, 4'hc};
  always #20 clk_i = ~clk_i;
  dmc_top #(.ZERO_RUN(8)) dut (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .wr_en_i         (wr_en_i),
    .wr_addr_i       (wr_addr_i),
    .wr_data_i       (wr_data_i),
    .rd_addr_i       (rd_addr_i),
    .rd_data_o       (rd_data_o),
    .mode_sel_i      (mode_sel_i),
    .sample_stb_i    (sample_stb_i),
    .sample_data_i   (sample_data_i),
    .mute_pin_i      (mute_pin_i),
    .mute_pin_o      (mute_pin_o),
    .mute_pin_oe_o   (mute_pin_oe_o),
    .zero_run_flag_o (zero_run_flag_o),
    .softmute_o      (softmute_o),
    .clamp_o         (clamp_o),
    .gain_o          (gain_o)
  );
  dmc_pin_model pin (
    .ext_drive_i   (ext_drive_i),
    .ext_level_i   (ext_level_i),
    .mute_pin_o    (mute_pin_o),
    .mute_pin_oe_o (mute_pin_oe_o),
    .mute_pin_i    (mute_pin_i)
  );
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk_i);
    {wr_en_i, wr_addr_i, wr_data_i} = {1'b1, a, d};
    @(negedge clk_i);
    wr_en_i = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    rd_addr_i = a;
    @(negedge clk_i);
    chk(rd_data_o, e);
  endtask
  task automatic fr(input int n, input logic [3:0] z);
    repeat (n)
    begin
      @(negedge clk_i);
      sample_stb_i = 1;
      for (int c = 0; c < 4; c++)
        sample_data_i[c*48+:48] = z[c] ? 48'h0 : 48'h1;
    end
    @(negedge clk_i);
    sample_stb_i = 0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    repeat (3) @(negedge clk_i);
    rstn_i = 1;
    wr(7'h05, 9'h1ff);
    rd(7'h05, 9'h000);
    rd(7'h02, 9'h000);
    rd(7'h09, 9'h000);
    rd(7'h0f, 9'h000);
    for (int m = 0; m < 16; m++)
    begin
      wr(7'h0f, {6'h0, m[3], 2'h0});
      wr(7'h09, {3'h0, m[2:0], 3'h0});
      repeat (2) @(negedge clk_i);
      chk(softmute_o, m[3:0]);
    end
    wr(7'h0f, 9'h000);
    wr(7'h09, 9'h000);
    wr(7'h02, 9'h011);
    repeat (2) @(negedge clk_i);
    chk(softmute_o, 4'hf);
    chk(clamp_o, 4'hf);
    fr(1, 4'h0);
    chk(gain_o, {4{16'hfc00}});
    mode_sel_i = 1;
    repeat (2) @(negedge clk_i);
    chk(clamp_o, 4'h0);
    mode_sel_i = 0;
    wr(7'h02, 9'h000);
    repeat (3) @(negedge clk_i);
    chk(gain_o, {4{16'hffff}});
    {ext_drive_i, ext_level_i} = 2'b11;
    for (int s = 0; s < 16; s++)
    begin
      wr(7'h09, {6'h0, s[1:0], 1'b0});
      wr(7'h0f, {8'h0, s[2]});
      wr(7'h02, {5'h0, s[3], 3'h0});
      repeat (2) @(negedge clk_i);
      chk(softmute_o, s[3] ? 4'hf : dec[s[2:0]]);
    end
    wr(7'h02, 9'h000);
    wr(7'h0f, 9'h000);
    wr(7'h09, 9'h000);
    ext_level_i = 0;
    fr(7, 4'hf);
    chk(zero_run_flag_o, 4'h0);
    fr(1, 4'hf);
    repeat (2) @(negedge clk_i);
    chk(zero_run_flag_o, 4'hf);
    chk(mute_pin_o, 1'b1);
    chk(softmute_o, 4'h0);
    wr(7'h09, 9'h008);
    @(negedge clk_i);
    chk(softmute_o, 4'h1);
    wr(7'h09, 9'h000);
    ext_drive_i = 0;
    repeat (2) @(negedge clk_i);
    chk(softmute_o, 4'hf);
    wr(7'h0f, 9'h001);
    fr(1, 4'he);
    repeat (3) @(negedge clk_i);
    chk(zero_run_flag_o, 4'he);
    chk(softmute_o, 4'h8);
    wr(7'h02, 9'h010);
    @(negedge clk_i);
    chk(clamp_o, 4'he);
    rstn_i = 0;
    @(negedge clk_i);
    chk(softmute_o, 4'h0);
    chk(clamp_o, 4'h0);
    chk(zero_run_flag_o, 4'h0);
    chk({mute_pin_oe_o, mute_pin_o}, 2'b00);
    chk(gain_o, {4{16'hffff}});
    rstn_i = 1;
    @(negedge clk_i);
    chk(softmute_o, 4'h0);
    chk(mute_pin_oe_o, 1'b1);
    rd(7'h0f, 9'h000);
    rd(7'h02, 9'h000);
    give_verdict;
  end
endmodule // dac_mute_control_logic_test
`default_nettype wire
